/* verilog/shm_monitor.sv */
// Purpose: watchdog, temperature and fan supervision with indicators
// Assumes: classic wishbone slave, one clock, sync active-low reset
// Notes: ack comes one cycle after the request; writes land with ack
//
// Summary of operation
// - after reset the watchdog idles, no reaction, run indicator dark
// - activation lights run indicator green and starts supervision
// - missed retrigger turns run indicator red and marks expiry
// - expiry also resets unit, interrupts, signals monitor app if enabled
// - timeout is 3 to 255 whole seconds; lower writes are raised to 3
// - writing the timeout while running retriggers from the new value
// - three sensors each compared with their own limits
// - supply area above 45 degrees with fan control on forces full fan
// - any sensor out of range latches error, red indicator, full fan
// - temperature error stays latched until acknowledged or reset
// - fan failure turns temperature indicator red, optional interrupt
// - fan error clears only after the fault is gone and acknowledged
// - run off/green/red is idle/active/expired; temp green normal
module shm_monitor
   import shm_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire shm_wbreq_s wbReq,
   output logic [31:0] wbDat_q,
   output logic wbAck_q,
   input wire shm_temps_s sensors,
   input wire logic fanFail,
   output shm_led_s runLed_q,
   output shm_led_s tempLed_q,
   output logic fanMax_q,
   output logic unitReset_q,
   output logic monitorAppReq_q,
   output logic irq_q
);
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   logic [CTRL_W-1:0] ctrl_q;
   logic [7:0] timeoutPeriod_q;
   shm_stat_s stat_q;
   shm_stat_s stat_d;
   shm_stat_s mask_q;
   logic [NSENS-1:0][15:0] limits_q;
   shm_dog_e dogState_q;
   logic [7:0] secLeft_q;
   logic [3:0] rstCnt_q;
   logic [NSENS-1:0][7:0] sensArr;
   logic [NSENS-1:0] hit;
   logic wbCommit;
   logic wbWr;
   logic wrCtrl;
   logic wrTimeout;
   logic wrKick;
   logic wrStatus;
   logic wrMask;
   logic wrLim0;
   logic wrLim1;
   logic kick;
   logic [7:0] newTimeout;
   logic dogLoad;
   logic tick;
   logic expireEv;
   logic psuHot;
   logic [31:0] rdData;
   logic [31:0] lim0Merged;
   logic [31:0] lim1Merged;

   // bus: ack rises the cycle after the request, commit at the ack edge
   assign wbCommit = wbReq.cyc && wbReq.stb && wbAck_q;
   assign wbWr = wbCommit && wbReq.we;
   assign wrCtrl = wbWr && (wbReq.adr == OFS_CTRL);
   assign wrTimeout = wbWr && (wbReq.adr == OFS_TIMEOUT) && wbReq.sel[0];
   assign wrKick = wbWr && (wbReq.adr == OFS_KICK) && wbReq.sel[0];
   assign wrStatus = wbWr && (wbReq.adr == OFS_STATUS) && wbReq.sel[0];
   assign wrMask = wbWr && (wbReq.adr == OFS_MASK) && wbReq.sel[0];
   assign wrLim0 = wbWr && (wbReq.adr == OFS_LIMITS0);
   assign wrLim1 = wbWr && (wbReq.adr == OFS_LIMITS1);
   assign kick = wrKick && wbReq.dat[KICK_BIT];
   // below-range values are raised to the minimum rather than refused
   assign newTimeout = (wbReq.dat[7:0] < TIMEOUT_MIN) ? TIMEOUT_MIN
                                                       : wbReq.dat[7:0];
   assign lim0Merged = mergeBytes({limits_q[1], limits_q[0]}, wbReq.dat, wbReq.sel);
   assign lim1Merged = mergeBytes({16'h0000, limits_q[2]}, wbReq.dat, wbReq.sel);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wbAck_q <= 1'b0;
      end else begin
         wbAck_q <= wbReq.cyc && wbReq.stb && !wbAck_q;
      end
   end

   always_comb begin
      rdData = 32'h0000_0000;
      if (wbReq.adr == OFS_CTRL) begin
         rdData[CTRL_W-1:0] = ctrl_q;
      end else if (wbReq.adr == OFS_TIMEOUT) begin
         rdData[7:0] = timeoutPeriod_q;
      end else if (wbReq.adr == OFS_STATUS) begin
         rdData[2:0] = stat_q;
      end else if (wbReq.adr == OFS_MASK) begin
         rdData[2:0] = mask_q;
      end else if (wbReq.adr == OFS_LIMITS0) begin
         rdData = {limits_q[1], limits_q[0]};
      end else if (wbReq.adr == OFS_LIMITS1) begin
         rdData[15:0] = limits_q[2];
      end else if (wbReq.adr == OFS_STATE) begin
         rdData[STATE_SEC_LSB +: 8] = secLeft_q;
         rdData[STATE_ACTIVE] = (dogState_q == DOG_ACTIVE);
         rdData[STATE_FAN_FAIL] = fanFail;
         rdData[STATE_RUN_LSB +: 2] = runLed_q;
         rdData[STATE_TEMP_LSB +: 2] = tempLed_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wbDat_q <= 32'h0000_0000;
      end else if (wbReq.cyc && wbReq.stb && !wbAck_q && !wbReq.we) begin
         wbDat_q <= rdData;
      end
   end

   // settings hold until rewritten or reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RST;
      end else if (wrCtrl && wbReq.sel[0]) begin
         ctrl_q <= wbReq.dat[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         timeoutPeriod_q <= TIMEOUT_RST;
      end else if (wrTimeout) begin
         timeoutPeriod_q <= newTimeout;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_q <= MASK_RST;
      end else if (wrMask) begin
         mask_q <= wbReq.dat[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < NSENS; i++) begin
            limits_q[i] <= {LIMIT_LO_RST, LIMIT_HI_RST};
         end
      end else if (wrLim0) begin
         limits_q[0] <= lim0Merged[15:0];
         limits_q[1] <= lim0Merged[31:16];
      end else if (wrLim1) begin
         limits_q[2] <= lim1Merged[15:0];
      end
   end

   // watchdog
   shm_sec_tick #(.SEC_CYC(SEC_CYC)) secTick (
      .clk(clk),
      .rst_b(rst_b),
      .restart(dogLoad),
      .tick(tick)
   );

   assign dogLoad = (dogState_q == DOG_STANDBY && ctrl_q[CTRL_ACT])
                    || (dogState_q == DOG_ACTIVE && (kick || wrTimeout));
   assign expireEv = (dogState_q == DOG_ACTIVE) && ctrl_q[CTRL_ACT] && !kick
                     && !wrTimeout && tick && (secLeft_q == 8'h01);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dogState_q <= DOG_STANDBY;
         secLeft_q <= TIMEOUT_RST;
      end else begin
         case (dogState_q)
            DOG_STANDBY: begin
               // kicks are ignored here
               if (ctrl_q[CTRL_ACT]) begin
                  dogState_q <= DOG_ACTIVE;
                  secLeft_q <= timeoutPeriod_q;
               end
            end
            DOG_ACTIVE: begin
               if (!ctrl_q[CTRL_ACT]) begin
                  dogState_q <= DOG_STANDBY;
               end else if (wrTimeout) begin
                  secLeft_q <= newTimeout;
               end else if (kick) begin
                  secLeft_q <= timeoutPeriod_q;
               end else if (expireEv) begin
                  dogState_q <= DOG_EXPIRED;
                  secLeft_q <= 8'h00;
               end else if (tick) begin
                  secLeft_q <= secLeft_q - 8'h01;
               end
            end
            DOG_EXPIRED: begin
               // stays red until software deactivates
               if (!ctrl_q[CTRL_ACT]) begin
                  dogState_q <= DOG_STANDBY;
               end
            end
            default: begin
               dogState_q <= DOG_STANDBY;
            end
         endcase
      end
   end

   // optional reactions on expiry
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         unitReset_q <= 1'b0;
         rstCnt_q <= 4'h0;
      end else if (expireEv && ctrl_q[CTRL_RST_EN]) begin
         unitReset_q <= 1'b1;
         rstCnt_q <= RST_PULSE_CYC - 4'h1;
      end else if (rstCnt_q != 4'h0) begin
         rstCnt_q <= rstCnt_q - 4'h1;
      end else begin
         unitReset_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         monitorAppReq_q <= 1'b0;
      end else begin
         monitorAppReq_q <= stat_q.expired && ctrl_q[CTRL_MON_EN];
      end
   end

   // temperature supervision
   assign sensArr = sensors;
   for (genvar g = 0; g < NSENS; g++) begin : gSens
      shm_temp_cmp cmp (
         .clk(clk),
         .rst_b(rst_b),
         .temp(sensArr[g]),
         .hiLimit(limits_q[g][7:0]),
         .loLimit(limits_q[g][15:8]),
         .outOfRange(hit[g])
      );
   end

   assign psuHot = sensors.psu > PSU_FAN_LIMIT;

   // sticky status, write one to clear, a set in the same cycle wins
   always_comb begin
      stat_d = stat_q;
      if (wrStatus) begin
         stat_d.expired = stat_q.expired && !wbReq.dat[0];
         stat_d.temp = stat_q.temp && !wbReq.dat[1];
         // fan error cannot be cleared while the fault persists
         stat_d.fan = stat_q.fan && !(wbReq.dat[2] && !fanFail);
      end
      stat_d.expired = stat_d.expired || expireEv;
      stat_d.temp = stat_d.temp || (|hit);
      stat_d.fan = stat_d.fan || fanFail;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fanMax_q <= 1'b0;
      end else begin
         fanMax_q <= stat_q.temp || (ctrl_q[CTRL_FAN_CTL] && psuHot);
      end
   end

   // indicators
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         runLed_q <= '0;
      end else begin
         case (dogState_q)
            DOG_ACTIVE: runLed_q <= '{green: 1'b1, red: 1'b0};
            DOG_EXPIRED: runLed_q <= '{green: 1'b0, red: 1'b1};
            default: runLed_q <= '0;
         endcase
      end
   end

   // off only while held in reset, i.e. system not running
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tempLed_q <= '0;
      end else if (stat_q.temp || stat_q.fan) begin
         tempLed_q <= '{green: 1'b0, red: 1'b1};
      end else begin
         tempLed_q <= '{green: 1'b1, red: 1'b0};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   standby_dark_a: assert property (
      dogState_q == DOG_STANDBY |=> runLed_q == '0 && !unitReset_q)
      else $error("run indicator lit or reset in standby");

   active_green_a: assert property (
      dogState_q == DOG_STANDBY && ctrl_q[CTRL_ACT]
      |=> dogState_q == DOG_ACTIVE ##1 runLed_q.green && !runLed_q.red)
      else $error("activation did not light green");

   expire_red_a: assert property (
      expireEv |=> stat_q.expired && dogState_q == DOG_EXPIRED ##1 runLed_q.red)
      else $error("expiry not marked red");

   reset_pulse_a: assert property (
      expireEv && ctrl_q[CTRL_RST_EN] |=> unitReset_q [*8] ##1 !unitReset_q)
      else $error("unit reset pulse length wrong");

   timeout_range_a: assert property (
      timeoutPeriod_q >= TIMEOUT_MIN)
      else $error("timeout below minimum");

   retrigger_load_a: assert property (
      dogState_q == DOG_ACTIVE && ctrl_q[CTRL_ACT] && wrTimeout
      |=> secLeft_q == timeoutPeriod_q && dogState_q == DOG_ACTIVE)
      else $error("timeout write did not retrigger");

   kick_reload_a: assert property (
      dogState_q == DOG_ACTIVE && ctrl_q[CTRL_ACT] && kick && !wrTimeout
      |=> secLeft_q == $past(timeoutPeriod_q))
      else $error("kick did not reload");

   temp_error_a: assert property (
      |hit |=> stat_q.temp ##1 fanMax_q && tempLed_q.red)
      else $error("temperature error reaction missing");

   psu_fan_a: assert property (
      ctrl_q[CTRL_FAN_CTL] && psuHot |=> fanMax_q)
      else $error("hot supply area without full fan");

   fan_hold_a: assert property (
      stat_q.fan && fanFail |=> stat_q.fan)
      else $error("fan error cleared while fault present");

   irq_level_a: assert property (
      |(stat_q & mask_q) |=> irq_q)
      else $error("unmasked event without interrupt");

   expire_seen_c: cover property (expireEv && ctrl_q[CTRL_RST_EN]);
   temp_error_c: cover property (|hit ##1 wrStatus);
   fan_error_c: cover property (fanFail ##1 !fanFail ##[1:20] wrStatus);
   retrigger_c: cover property (dogState_q == DOG_ACTIVE && kick);
endmodule

/* verilog/shm_pkg.sv */
// Purpose: shared constants and types of the system health monitor
// Assumes: 100 MHz clock, 32-bit classic wishbone register port
// Notes: temperatures are unsigned whole degrees celsius
package shm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIMEOUT = 8'h04;
   localparam logic [7:0] OFS_KICK = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_LIMITS0 = 8'h14;
   localparam logic [7:0] OFS_LIMITS1 = 8'h18;
   localparam logic [7:0] OFS_STATE = 8'h1c;
   // control field positions
   localparam int CTRL_ACT = 0;
   localparam int CTRL_RST_EN = 1;
   localparam int CTRL_MON_EN = 2;
   localparam int CTRL_FAN_CTL = 3;
   localparam int CTRL_W = 4;
   // state register field positions
   localparam int STATE_SEC_LSB = 0;
   localparam int STATE_ACTIVE = 8;
   localparam int STATE_FAN_FAIL = 9;
   localparam int STATE_RUN_LSB = 10;
   localparam int STATE_TEMP_LSB = 12;
   // kick register field
   localparam int KICK_BIT = 0;
   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [7:0] TIMEOUT_RST = 8'hff;
   localparam logic [7:0] LIMIT_HI_RST = 8'h50;
   localparam logic [7:0] LIMIT_LO_RST = 8'h05;
   localparam logic [2:0] MASK_RST = 3'h0;
   // timeout range in seconds
   localparam logic [7:0] TIMEOUT_MIN = 8'h03;
   localparam logic [7:0] TIMEOUT_MAX = 8'hff;
   // fixed supply-area fan threshold, degrees
   localparam logic [7:0] PSU_FAN_LIMIT = 8'h2d;
   // timing
   localparam longint ONE_SEC_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 10;
   localparam int unsigned SEC_CYCLES = int'(ONE_SEC_NS / CLK_PERIOD_NS);
   localparam logic [3:0] RST_PULSE_CYC = 4'h8;
   localparam int NSENS = 3;

   typedef enum logic [1:0] {DOG_STANDBY, DOG_ACTIVE, DOG_EXPIRED} shm_dog_e;

   typedef struct packed {
      logic green;
      logic red;
   } shm_led_s;

   typedef struct packed {
      logic fan;
      logic temp;
      logic expired;
   } shm_stat_s;

   typedef struct packed {
      logic [7:0] psu;
      logic [7:0] mem;
      logic [7:0] cpu;
   } shm_temps_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } shm_wbreq_s;
endpackage

/* verilog/shm_sec_tick.sv */
// Purpose: one-second prescaler for the timeout counter
// Assumes: restart is a one-cycle pulse from the watchdog
// Notes: restart realigns the second so a reload gives a full interval
module shm_sec_tick
   import shm_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(SEC_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(SEC_CYC - 1);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (!rst_b || restart) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign tick = (cnt_q == LAST) && !restart;
endmodule

/* verilog/shm_temp_cmp.sv */
// Purpose: window compare of one temperature sensor
// Assumes: sensor value synchronous to clk
// Notes: result registered, one cycle behind the sensor
module shm_temp_cmp
   import shm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] temp,
   input wire logic [7:0] hiLimit,
   input wire logic [7:0] loLimit,
   output logic outOfRange
);
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         outOfRange <= 1'b0;
      end else begin
         outOfRange <= (temp > hiLimit) || (temp < loLimit);
      end
   end
endmodule

/* verif/shm_host_model.sv */
// Purpose: host driver model issuing classic wishbone single cycles
// Assumes: ack sampled at the rising edge, one request at a time
// Notes: waits for ack without limit, the bench watchdog cuts hangs
module shm_host_model
   import shm_pkg::*;
(
   input wire logic clk,
   input wire logic wbAck,
   output shm_wbreq_s wbReq
);
   timeunit 1ns;
   timeprecision 1ps;

   initial wbReq = '0;

   // request held until the edge that samples ack, then released
   task automatic cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
      do @(posedge clk); while (wbAck !== 1'b1);
      wbReq.cyc <= 1'b0;
      wbReq.stb <= 1'b0;
   endtask

   // errors acknowledged by writing ones to the sticky bits
   task automatic ackErrors(input logic [2:0] bits);
      cycle(1'b1, OFS_STATUS, {29'h0, bits}, 4'h1);
   endtask

   // sec written unchanged in lane 0; the device raises values below 3
   task automatic setTimeout(input logic [7:0] sec);
      cycle(1'b1, OFS_TIMEOUT, {24'h0, sec}, 4'h1);
   endtask
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench of the health monitor
// Assumes: second shortened to 20 cycles
// Notes: read data checked against a queue of expected words
module testbench
   import shm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 20;
   localparam logic [7:0] RED = 8'h01;
   localparam logic [7:0] GRN = 8'h02;
   typedef struct packed {logic [31:0] val; logic [31:0] msk;} shm_note_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   shm_wbreq_s wbReq;
   logic [31:0] wbDat_q;
   logic wbAck_q;
   shm_temps_s sensors = '{psu: 8'h14, mem: 8'h14, cpu: 8'h14};
   logic fanFail = 1'b0;
   shm_led_s runLed_q;
   shm_led_s tempLed_q;
   logic fanMax_q;
   logic unitReset_q;
   logic monitorAppReq_q;
   logic irq_q;
   shm_note_s notes[$];
   int num_errors = 0;
   int samples_checked = 0;
   int rstLen = 0;
   logic [31:0] seed = 32'd11622;

   always #5 clk = ~clk;

   shm_monitor #(.SEC_CYC(SC)) dut_u (.clk(clk), .rst_b(rst_b), .wbReq(wbReq),
      .wbDat_q(wbDat_q), .wbAck_q(wbAck_q), .sensors(sensors), .fanFail(fanFail),
      .runLed_q(runLed_q), .tempLed_q(tempLed_q), .fanMax_q(fanMax_q),
      .unitReset_q(unitReset_q), .monitorAppReq_q(monitorAppReq_q), .irq_q(irq_q));
   shm_host_model hostU (.clk(clk), .wbAck(wbAck_q), .wbReq(wbReq));

   function automatic logic [7:0] rv();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      // kept inside default limits and at or below the fan threshold
      return 8'h0a + 8'(seed % 36);
   endfunction

   task automatic cmpLvl(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read results taken off the queue as each read ack appears
   always @(posedge clk) begin
      shm_note_s n;
      if (unitReset_q === 1'b1) rstLen++;
      if (wbAck_q === 1'b1 && wbReq.cyc === 1'b1 && wbReq.we === 1'b0) begin
         n = notes.pop_front();
         cmpWord(wbDat_q & n.msk, n.val & n.msk);
      end
   end

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      notes.push_back('{val: e, msk: m});
      hostU.cycle(1'b0, a, 32'h0, 4'hf);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
      hostU.cycle(1'b1, a, d, s);
   endtask

   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic newTemps();
      @(posedge clk);
      sensors <= '{psu: rv(), mem: rv(), cpu: rv()};
   endtask

   task automatic waitRed(output int cnt);
      cnt = 0;
      while (8'(runLed_q) !== RED && cnt < 500) begin
         @(posedge clk);
         cnt++;
      end
   endtask

   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // whole run is about 1000 cycles
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial begin
      int cnt;
      logic [7:0] v;
      logic [31:0] d;
      waitCyc(2);
      cmpLvl(8'(tempLed_q), 8'h0);
      rst_b <= 1'b1;
      waitCyc(2);
      cmpLvl(8'(runLed_q), 8'h0);
      cmpLvl(8'(tempLed_q), GRN);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_TIMEOUT, {24'h0, TIMEOUT_RST});
      rd(OFS_MASK, 32'h0);
      rd(OFS_LIMITS0, {LIMIT_LO_RST, LIMIT_HI_RST, LIMIT_LO_RST, LIMIT_HI_RST});
      rd(OFS_LIMITS1, {16'h0, LIMIT_LO_RST, LIMIT_HI_RST});
      rd(8'h20, 32'h0);
      wr(OFS_KICK, 32'h1);
      waitCyc(300);
      cmpLvl(8'(runLed_q), 8'h0);
      cmpLvl(8'(unitReset_q), 8'h0);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_TIMEOUT, 32'h1);
      rd(OFS_TIMEOUT, {24'h0, TIMEOUT_MIN});
      wr(OFS_MASK, 32'h7);
      wr(OFS_CTRL, 32'h7);
      waitCyc(3);
      cmpLvl(8'(runLed_q), GRN);
      rd(OFS_STATE, 32'h900, 32'hd00);
      // alternate kicks and timeout rewrites, each before the 60-cycle limit
      for (int i = 0; i < 6; i++) begin
         waitCyc(2 * SC);
         if (i % 2 == 1) wr(OFS_KICK, 32'h1);
         else hostU.setTimeout(TIMEOUT_MIN);
      end
      cmpLvl(8'(runLed_q), GRN);
      rstLen = 0;
      waitRed(cnt);
      cmpLvl(8'(cnt >= 3 * SC - 2 && cnt <= 3 * SC + 4), 8'h1);
      waitCyc(12);
      cmpLvl(8'(rstLen), 8'(RST_PULSE_CYC));
      cmpLvl(8'(monitorAppReq_q), 8'h1);
      cmpLvl(8'(irq_q), 8'h1);
      rd(OFS_STATUS, 32'h1, 32'h1);
      rd(OFS_STATE, 32'h400, 32'hc00);
      wr(OFS_CTRL, 32'h0);
      hostU.ackErrors(3'h1);
      waitCyc(3);
      cmpLvl(8'(runLed_q), 8'h0);
      cmpLvl(8'(irq_q), 8'h0);
      // expiry with every optional reaction off
      wr(OFS_MASK, 32'h0);
      wr(OFS_CTRL, 32'h1);
      rstLen = 0;
      waitRed(cnt);
      waitCyc(12);
      cmpLvl(8'(runLed_q), RED);
      cmpLvl(8'(rstLen), 8'h0);
      cmpLvl(8'(monitorAppReq_q), 8'h0);
      cmpLvl(8'(irq_q), 8'h0);
      wr(OFS_CTRL, 32'h0);
      hostU.ackErrors(3'h1);
      // each sensor above high then below low; irq only on high cases
      for (int k = 0; k < 6; k++) begin
         v = (k % 2 == 1) ? LIMIT_LO_RST - 8'h1 : LIMIT_HI_RST + 8'h1;
         wr(OFS_MASK, (k % 2 == 1) ? 32'h0 : 32'h2);
         newTemps();
         @(posedge clk);
         if (k < 2) sensors.cpu <= v;
         else if (k < 4) sensors.mem <= v;
         else sensors.psu <= v;
         waitCyc(4);
         cmpLvl(8'(tempLed_q), RED);
         cmpLvl(8'(fanMax_q), 8'h1);
         cmpLvl(8'(irq_q), (k % 2 == 1) ? 8'h0 : 8'h1);
         rd(OFS_STATUS, 32'h2, 32'h2);
         newTemps();
         waitCyc(4);
         cmpLvl(8'(tempLed_q), RED);
         hostU.ackErrors(3'h2);
         waitCyc(4);
         cmpLvl(8'(tempLed_q), GRN);
         cmpLvl(8'(fanMax_q), 8'h0);
         cmpLvl(8'(irq_q), 8'h0);
      end
      // supply area at and above the fixed limit, fan control off and on
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CTRL, (k > 1) ? 32'h8 : 32'h0);
         @(posedge clk);
         sensors.psu <= (k % 2 == 1) ? PSU_FAN_LIMIT + 8'h1 : PSU_FAN_LIMIT;
         waitCyc(4);
         cmpLvl(8'(fanMax_q), (k == 3) ? 8'h1 : 8'h0);
      end
      wr(OFS_CTRL, 32'h0);
      newTemps();
      @(posedge clk);
      fanFail <= 1'b1;
      waitCyc(4);
      cmpLvl(8'(tempLed_q), RED);
      cmpLvl(8'(irq_q), 8'h0);
      wr(OFS_MASK, 32'h4);
      waitCyc(3);
      cmpLvl(8'(irq_q), 8'h1);
      rd(OFS_STATE, 32'h200, 32'h200);
      // acknowledge while the fault persists must not clear
      hostU.ackErrors(3'h4);
      waitCyc(3);
      rd(OFS_STATUS, 32'h4, 32'h4);
      @(posedge clk);
      fanFail <= 1'b0;
      waitCyc(4);
      cmpLvl(8'(tempLed_q), RED);
      hostU.ackErrors(3'h4);
      waitCyc(4);
      cmpLvl(8'(tempLed_q), GRN);
      cmpLvl(8'(irq_q), 8'h0);
      // only lane 0 written, upper lanes carry noise
      d = {rv(), rv(), rv(), 8'h30};
      wr(OFS_LIMITS0, d, 4'h1);
      rd(OFS_LIMITS0, {LIMIT_LO_RST, LIMIT_HI_RST, LIMIT_LO_RST, 8'h30});
      @(posedge clk);
      sensors.cpu <= 8'h31;
      waitCyc(4);
      cmpLvl(8'(fanMax_q), 8'h1);
      rd(OFS_STATUS, 32'h2, 32'h2);
      stop_test();
   end
endmodule
